// file: rtl/via_pkg.sv
// via_pkg: constants shared by the vectored interrupt arbiter files.
// assumes a byte-wide program memory with 15-bit addresses.
package via_pkg;
  localparam int          PC_W         = 15;
  localparam int          NSRC         = 14;
  localparam int          NSLOT        = 16;
  localparam logic [7:0]  VEC_BASE     = 8'he0;
  localparam logic [7:0]  BLOCK_TOP    = 8'hff;
  localparam logic [7:0]  TRAP_OPCODE  = 8'h00;
  localparam logic [14:0] PC_ACK       = 15'h00ff;
  localparam logic [14:0] PC_OVERPOP   = 15'h7fff;
  localparam logic [7:0]  SP_LIMIT     = 8'h6f;
  localparam int          ACK_CYCLES   = 7;
  localparam logic [2:0]  ACK_LAST     = 3'(ACK_CYCLES - 1);
  localparam int          PROG_BYTES   = 32768;
  // register map
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_ENABLE   = 8'h04;
  localparam logic [7:0]  REG_ACTIVE   = 8'h08;
  localparam logic [7:0]  REG_VECTOR   = 8'h0c;
  localparam int          CTRL_GIE_BIT = 0;
  localparam int          ACT_BUSY_BIT = 16;
  localparam int          VEC_PC_LSB   = 16;
  localparam logic        GIE_RST      = 1'b0;
  localparam logic [13:0] ENABLE_RST   = 14'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;
  typedef enum logic [2:0] {
    VIA_IDLE, VIA_ACK, VIA_VIS_HI, VIA_VIS_LO, VIA_VIS_LD
  } via_state_e;
endpackage

// file: rtl/via_arb.sv
// via_arb: fixed-rank pick among the trap, fourteen maskable slots
// and the default slot; assumes pending and enable come from this clock.
`timescale 1ns/1ns
`default_nettype none
module via_arb (
  input  wire logic                    trap_pending_in,
  input  wire logic [via_pkg::NSRC-1:0] enable_in,
  input  wire logic [via_pkg::NSRC-1:0] pend_in,
  output logic      [7:0]              vec_byte_out
);
  logic [via_pkg::NSLOT-1:0] act;
  logic [3:0]                idx;

  assign act[0] = 1'b1;
  assign act[via_pkg::NSLOT-1] = trap_pending_in;
  genvar g;
  generate
    for (g = 0; g < via_pkg::NSRC; g++) begin : g_act
      assign act[g+1] = enable_in[g] & pend_in[g];
    end
  endgenerate

  // later slots rank higher, so the last hit wins
  always_comb begin
    idx = 4'h0;
    for (int i = 0; i < via_pkg::NSLOT; i++) begin
      if (act[i]) begin
        idx = 4'(i);
      end
    end
  end

  assign vec_byte_out = via_pkg::VEC_BASE | {3'h0, idx, 1'b0};
endmodule
`default_nettype wire

// file: rtl/via_fetch_guard.sv
// via_fetch_guard: screens instruction bytes on their way to the
// instruction register; assumes raw data is valid with its address.
`timescale 1ns/1ns
`default_nettype none
module via_fetch_guard #(
  parameter int PROG_BYTES = via_pkg::PROG_BYTES
) (
  input  wire logic [via_pkg::PC_W-1:0] addr_in,
  input  wire logic [7:0]               raw_in,
  output logic      [7:0]               data_out,
  output logic                          is_trap_out
);
  logic beyond;
  logic overpop;

  assign beyond  = 32'(addr_in) >= PROG_BYTES;
  // the over-pop landing address never yields code
  assign overpop = addr_in == via_pkg::PC_OVERPOP;
  assign data_out = (beyond | overpop) ? via_pkg::TRAP_OPCODE
                                       : raw_in;
  assign is_trap_out = data_out == via_pkg::TRAP_OPCODE;
endmodule
`default_nettype wire

// file: rtl/via_top.sv
// via_top: interrupt acknowledge, software trap flag and vector-select
// sequencing, with an AXI4-Lite register slave.
// assumes core strobes, pending bits and memory data share clk_in, and
// program memory answers a read one cycle after pm_rd_out.
`timescale 1ns/1ns
`default_nettype none
module via_top #(
  parameter int PROG_BYTES = via_pkg::PROG_BYTES
) (
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  input  wire logic [7:0]               s_axi_awaddr_in,
  input  wire logic                     s_axi_awvalid_in,
  output logic                          s_axi_awready_out,
  input  wire logic [31:0]              s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  input  wire logic                     s_axi_wvalid_in,
  output logic                          s_axi_wready_out,
  output logic      [1:0]               s_axi_bresp_out,
  output logic                          s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  input  wire logic [7:0]               s_axi_araddr_in,
  input  wire logic                     s_axi_arvalid_in,
  output logic                          s_axi_arready_out,
  output logic      [31:0]              s_axi_rdata_out,
  output logic      [1:0]               s_axi_rresp_out,
  output logic                          s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  input  wire logic                     instr_start_in,
  input  wire logic [via_pkg::PC_W-1:0] next_pc_in,
  input  wire logic                     vector_select_instr_in,
  input  wire logic [via_pkg::PC_W-1:0] vis_pc_in,
  input  wire logic                     clear_trap_pending_instr_in,
  input  wire logic                     irq_return_instr_in,
  input  wire logic                     fetch_valid_in,
  input  wire logic [via_pkg::PC_W-1:0] fetch_addr_in,
  input  wire logic [7:0]               fetch_raw_in,
  input  wire logic                     stack_pop_in,
  input  wire logic [7:0]               sp_in,
  input  wire logic [via_pkg::NSRC-1:0] pend_in,
  input  wire logic [7:0]               pm_data_in,
  output logic      [7:0]               fetch_data_out,
  output logic                          ir_load_out,
  output logic                          pm_rd_out,
  output logic      [via_pkg::PC_W-1:0] pm_addr_out,
  output logic                          pc_load_out,
  output logic      [via_pkg::PC_W-1:0] pc_val_out,
  output logic                          push_out,
  output logic      [via_pkg::PC_W-1:0] push_addr_out,
  output logic                          busy_out,
  output logic                          global_irq_enable_out
);
  logic rst_q1;
  logic rst_q2;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  via_pkg::via_state_e     state_q;
  logic                    trap_q;
  logic                    gie_q;
  logic [via_pkg::NSRC-1:0] enable_q;
  logic [2:0]              cnt_q;
  logic [7:0]              vis_byte_q;
  logic [6:0]              vec_hi_q;
  logic [via_pkg::PC_W-1:0] last_vec_q;

  // ---------------- arbitration and fetch screening ----------------
  logic [7:0] arb_byte;
  logic [7:0] guard_data;
  logic       guard_trap;

  via_arb u_arb (
    .trap_pending_in (trap_q),
    .enable_in       (enable_q),
    .pend_in         (pend_in),
    .vec_byte_out    (arb_byte)
  );

  via_fetch_guard #(.PROG_BYTES(PROG_BYTES)) u_guard (
    .addr_in     (fetch_addr_in),
    .raw_in      (fetch_raw_in),
    .data_out    (guard_data),
    .is_trap_out (guard_trap)
  );

  logic       idle;
  logic       trap_hit;
  logic       mask_hit;
  logic       any_active;
  logic       vis_go;
  logic [6:0] tbl_hi;
  logic       overpop;

  assign idle       = state_q == via_pkg::VIA_IDLE;
  assign trap_hit   = fetch_valid_in & guard_trap;
  assign any_active = |(enable_q & pend_in);
  // a set trap flag locks out every maskable request
  assign mask_hit   = idle & instr_start_in & gie_q & any_active
                      & ~trap_q & ~trap_hit;
  assign vis_go     = idle & vector_select_instr_in & ~trap_hit;
  // a select at the top byte of a block reads the next block's table
  assign tbl_hi     = (vis_pc_in[7:0] == via_pkg::BLOCK_TOP)
                      ? vis_pc_in[14:8] + 7'h01
                      : vis_pc_in[14:8];
  assign overpop    = stack_pop_in & (sp_in > via_pkg::SP_LIMIT);

  // ---------------- trap flag ----------------
  // not mapped into any register: only the opcode and the clear
  // instruction reach it; a trap in the clear cycle still sets it
  always_ff @(posedge clk_in or negedge rst_q2) begin
    if (!rst_q2) begin
      trap_q <= 1'b0;
    end else if (trap_hit) begin
      trap_q <= 1'b1;
    end else if (clear_trap_pending_instr_in) begin
      trap_q <= 1'b0;
    end
  end

  // ---------------- register bus ----------------
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_wr;
  logic        wr_ctrl;
  logic        wr_en;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;

  assign do_wr   = aw_q & w_q & ~s_axi_bvalid_out;
  assign wr_ctrl = do_wr & (awaddr_q == via_pkg::REG_CTRL) & wstrb_q[0];
  assign wr_en   = do_wr & (awaddr_q == via_pkg::REG_ENABLE);
  assign wr_hit  = (awaddr_q == via_pkg::REG_CTRL)
                 | (awaddr_q == via_pkg::REG_ENABLE);
  assign rd_hit  = (s_axi_araddr_in == via_pkg::REG_CTRL)
                 | (s_axi_araddr_in == via_pkg::REG_ENABLE)
                 | (s_axi_araddr_in == via_pkg::REG_ACTIVE)
                 | (s_axi_araddr_in == via_pkg::REG_VECTOR);
  assign rd_word =
    (s_axi_araddr_in == via_pkg::REG_CTRL)   ? {31'h0, gie_q} :
    (s_axi_araddr_in == via_pkg::REG_ENABLE) ? {18'h0, enable_q} :
    (s_axi_araddr_in == via_pkg::REG_ACTIVE)
      ? {15'h0, ~idle, 2'h0, enable_q & pend_in} :
    (s_axi_araddr_in == via_pkg::REG_VECTOR)
      ? {1'b0, last_vec_q, 8'h0, vis_byte_q} : 32'h0;

  always_ff @(posedge clk_in or negedge rst_q2) begin
    if (!rst_q2) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid_in & s_axi_awready_out) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end else if (do_wr) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid_in & s_axi_wready_out) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end else if (do_wr) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_q2) begin
    if (!rst_q2) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= via_pkg::RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rresp_out   <= via_pkg::RESP_OKAY;
      s_axi_rdata_out   <= 32'h0;
    end else begin
      // one write in flight: ready drops once a half is taken
      s_axi_awready_out <= ~aw_q & ~(s_axi_awvalid_in & s_axi_awready_out)
                           & ~s_axi_bvalid_out;
      s_axi_wready_out  <= ~w_q & ~(s_axi_wvalid_in & s_axi_wready_out)
                           & ~s_axi_bvalid_out;
      if (do_wr) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? via_pkg::RESP_OKAY
                                   : via_pkg::RESP_DECERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out
                           & s_axi_arvalid_in;
      if (s_axi_arvalid_in & s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_hit ? rd_word : 32'h0;
        s_axi_rresp_out  <= rd_hit ? via_pkg::RESP_OKAY
                                   : via_pkg::RESP_DECERR;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ---------------- enables ----------------
  always_ff @(posedge clk_in or negedge rst_q2) begin
    if (!rst_q2) begin
      enable_q <= via_pkg::ENABLE_RST;
    end else if (wr_en) begin
      enable_q[7:0]  <= wstrb_q[0] ? wdata_q[7:0] : enable_q[7:0];
      enable_q[13:8] <= wstrb_q[1] ? wdata_q[13:8] : enable_q[13:8];
    end
  end

  // acknowledge is checked first, so its clear of the global enable beats a return
  always_ff @(posedge clk_in or negedge rst_q2) begin
    if (!rst_q2) begin
      gie_q <= via_pkg::GIE_RST;
    end else if (mask_hit) begin
      gie_q <= 1'b0;
    end else if (irq_return_instr_in) begin
      gie_q <= 1'b1;
    end else if (wr_ctrl) begin
      gie_q <= wdata_q[via_pkg::CTRL_GIE_BIT];
    end
  end

  // ---------------- acknowledge and vector-select sequencer ----------
  always_ff @(posedge clk_in or negedge rst_q2) begin
    if (!rst_q2) begin
      state_q       <= via_pkg::VIA_IDLE;
      cnt_q         <= 3'h0;
      vis_byte_q    <= via_pkg::VEC_BASE;
      vec_hi_q      <= 7'h00;
      last_vec_q    <= 15'h0;
      pm_rd_out     <= 1'b0;
      pm_addr_out   <= 15'h0;
      pc_load_out   <= 1'b0;
      pc_val_out    <= 15'h0;
      push_out      <= 1'b0;
      push_addr_out <= 15'h0;
    end else begin
      pc_load_out <= 1'b0;
      push_out    <= 1'b0;
      case (state_q)
        via_pkg::VIA_IDLE: begin
          pm_rd_out <= 1'b0;
          if (trap_hit) begin
            // trap is taken at once, leaving the global enable alone
            push_out      <= 1'b1;
            push_addr_out <= fetch_addr_in;
            cnt_q         <= 3'h1;
            state_q       <= via_pkg::VIA_ACK;
          end else if (mask_hit) begin
            push_out      <= 1'b1;
            push_addr_out <= next_pc_in;
            cnt_q         <= 3'h1;
            state_q       <= via_pkg::VIA_ACK;
          end else if (vis_go) begin
            // choice frozen here; later request changes are ignored
            vis_byte_q  <= arb_byte;
            pc_load_out <= 1'b1;
            pc_val_out  <= {tbl_hi, arb_byte};
            pm_rd_out   <= 1'b1;
            pm_addr_out <= {tbl_hi, arb_byte};
            state_q     <= via_pkg::VIA_VIS_HI;
          end else if (overpop) begin
            pc_load_out <= 1'b1;
            pc_val_out  <= via_pkg::PC_OVERPOP;
          end
        end
        via_pkg::VIA_ACK: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == via_pkg::ACK_LAST) begin
            pc_load_out <= 1'b1;
            pc_val_out  <= via_pkg::PC_ACK;
            state_q     <= via_pkg::VIA_IDLE;
          end
        end
        via_pkg::VIA_VIS_HI: begin
          pm_addr_out <= pm_addr_out + 15'h1;
          state_q     <= via_pkg::VIA_VIS_LO;
        end
        via_pkg::VIA_VIS_LO: begin
          vec_hi_q  <= pm_data_in[6:0];
          pm_rd_out <= 1'b0;
          state_q   <= via_pkg::VIA_VIS_LD;
        end
        via_pkg::VIA_VIS_LD: begin
          pc_load_out <= 1'b1;
          pc_val_out  <= {vec_hi_q, pm_data_in};
          last_vec_q  <= {vec_hi_q, pm_data_in};
          state_q     <= via_pkg::VIA_IDLE;
        end
        default: begin
          state_q <= via_pkg::VIA_IDLE;
        end
      endcase
    end
  end

  // ---------------- instruction register feed ----------------
  always_ff @(posedge clk_in or negedge rst_q2) begin
    if (!rst_q2) begin
      fetch_data_out        <= via_pkg::TRAP_OPCODE;
      ir_load_out           <= 1'b0;
      busy_out              <= 1'b0;
      global_irq_enable_out <= via_pkg::GIE_RST;
    end else begin
      fetch_data_out        <= fetch_valid_in ? guard_data
                                              : fetch_data_out;
      ir_load_out           <= fetch_valid_in;
      busy_out              <= ~idle | trap_hit | mask_hit | vis_go;
      global_irq_enable_out <= gie_q;
    end
  end
endmodule
`default_nettype wire

// file: tb/via_pm_model.sv
// via_pm_model: program memory answering the vector table reads
// assumes a read is answered on the cycle after pm_rd_out is seen
`timescale 1ns/1ns
`default_nettype none
module via_pm_model (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic [14:0] addr_in,
  output logic      [7:0]  data_out
);
  logic [7:0] q = 8'h3c;
  assign data_out = q;
  // bit 7 of an even byte is set so a vector that keeps it is caught
  always_ff @(posedge clk_in) begin
    if (rd_in) begin
      q <= addr_in[0] ? addr_in[7:0] ^ 8'h5a : {1'b1, addr_in[13:7]};
    end else begin
      q <= ~q;
    end
  end
endmodule
`default_nettype wire

// file: tb/via_top_asserts.sv
// via_chk: timing properties of via_top at its ports
// assumes one clock domain; bound to every via_top below
`timescale 1ns/1ns
`default_nettype none
module via_chk #(
  parameter int PROG_BYTES = 256
) (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        fetch_valid_in,
  input wire logic [14:0] fetch_addr_in,
  input wire logic [7:0]  fetch_raw_in,
  input wire logic        stack_pop_in,
  input wire logic [7:0]  sp_in,
  input wire logic [7:0]  fetch_data_out,
  input wire logic        ir_load_out,
  input wire logic        pm_rd_out,
  input wire logic [14:0] pm_addr_out,
  input wire logic        pc_load_out,
  input wire logic [14:0] pc_val_out,
  input wire logic        push_out,
  input wire logic [14:0] push_addr_out,
  input wire logic        busy_out,
  input wire logic        global_irq_enable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // beyond memory and at the over-pop slot the byte is forced to zero
  wire logic blank = fetch_addr_in >= PROG_BYTES || fetch_addr_in == 15'h7fff;
  wire logic trap = fetch_valid_in && !busy_out &&
                    (blank || fetch_raw_in == 8'h00);
  AST_TBL_BYTE: assert property (pc_load_out && pm_rd_out |->
    pc_val_out == pm_addr_out && pc_val_out[7:5] == 3'h7 && !pc_val_out[0])
    else $error("bad table address");
  AST_TBL_NEXT: assert property ($rose(pm_rd_out) |=> pm_rd_out &&
    pm_addr_out == $past(pm_addr_out) + 15'h1)
    else $error("second vector byte not next");
  AST_VEC_LOAD: assert property ($rose(pm_rd_out) |-> ##3 pc_load_out)
    else $error("vector load late");
  AST_TRAP_PUSH: assert property (trap |=> push_out && ir_load_out &&
    push_addr_out == $past(fetch_addr_in) && fetch_data_out == 8'h00)
    else $error("trap push wrong");
  AST_ACK_WAIT: assert property ($rose(push_out) |=> !pc_load_out [*5])
    else $error("entry jump early");
  AST_ACK_JUMP: assert property ($rose(push_out) |-> ##6 pc_load_out &&
    pc_val_out == via_pkg::PC_ACK)
    else $error("entry jump wrong");
  AST_OVERPOP: assert property (stack_pop_in && !busy_out &&
    sp_in > via_pkg::SP_LIMIT |=> pc_load_out &&
    pc_val_out == via_pkg::PC_OVERPOP)
    else $error("over-pop load wrong");
  AST_GIE_TRAP: assert property (trap |-> ##3
    global_irq_enable_out == $past(global_irq_enable_out, 3))
    else $error("trap changed global enable");
  cover property ($rose(pm_rd_out) ##3 pc_load_out);
  cover property (trap ##1 push_out);
  cover property (stack_pop_in && sp_in > via_pkg::SP_LIMIT);
endmodule
bind via_top via_chk #(.PROG_BYTES(PROG_BYTES)) u_chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .fetch_valid_in(fetch_valid_in),
  .fetch_addr_in(fetch_addr_in), .fetch_raw_in(fetch_raw_in),
  .stack_pop_in(stack_pop_in), .sp_in(sp_in),
  .fetch_data_out(fetch_data_out), .ir_load_out(ir_load_out),
  .pm_rd_out(pm_rd_out), .pm_addr_out(pm_addr_out),
  .pc_load_out(pc_load_out), .pc_val_out(pc_val_out),
  .push_out(push_out), .push_addr_out(push_addr_out),
  .busy_out(busy_out), .global_irq_enable_out(global_irq_enable_out));
`default_nettype wire

// file: tb/vectored_irq_arbiter_trap_tb.sv
// vectored_irq_arbiter_trap_tb: random and corner checks of via_top
// assumes via_chk is bound in its own file; memory is via_pm_model
`timescale 1ns/1ns
`default_nettype none
module vectored_irq_arbiter_trap_tb;
  logic        clk_in = 1'b0, nrst_in = 1'b0;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00, sp = 8'h00, fr = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic [3:0]  w_s = 4'h0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic        ist = 1'b0, vector_select_instr = 1'b0, clr = 1'b0, fv = 1'b0, pop = 1'b0;
  logic [14:0] npc = 15'h0, vpc = 15'h0, fa = 15'h0;
  logic [13:0] pend = 14'h0;
  logic        aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, irl, pmrd, pcl, push;
  logic        busy, global_irq_enable, ret = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  fdata, pmd;
  logic [14:0] pmaddr, pcv, pusha;
  int          error_cnt = 0, tests_run = 0;
  always #5 clk_in = ~clk_in;
  via_top #(.PROG_BYTES(256)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .s_axi_awaddr_in(aw_a),
    .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_rdy),
    .s_axi_wdata_in(w_d), .s_axi_wstrb_in(w_s), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_rdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(r_r), .instr_start_in(ist), .next_pc_in(npc),
    .vector_select_instr_in(vector_select_instr), .vis_pc_in(vpc),
    .clear_trap_pending_instr_in(clr), .irq_return_instr_in(ret),
    .fetch_valid_in(fv), .fetch_addr_in(fa), .fetch_raw_in(fr),
    .stack_pop_in(pop), .sp_in(sp), .pend_in(pend), .pm_data_in(pmd),
    .fetch_data_out(fdata), .ir_load_out(irl), .pm_rd_out(pmrd),
    .pm_addr_out(pmaddr), .pc_load_out(pcl), .pc_val_out(pcv),
    .push_out(push), .push_addr_out(pusha), .busy_out(busy),
    .global_irq_enable_out(global_irq_enable));
  via_pm_model u_mem (.clk_in(clk_in), .rd_in(pmrd), .addr_in(pmaddr),
    .data_out(pmd));
  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n > 40) begin
      chk("timeout", 32'h0, 32'h1);
      test_done();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_in);
    aw_a <= a;
    w_d <= d;
    w_s <= 4'hf;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge clk_in);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
      tmo(++n);
    end while (bvalid !== 1'b1);
    b_r <= 1'b0;
    chk("bresp", 32'(via_pkg::RESP_OKAY), 32'(bresp));
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    int n = 0;
    @(posedge clk_in);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge clk_in);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      tmo(++n);
    end while (rvalid !== 1'b1);
    r_r <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  task automatic wait_pc(output logic [14:0] v, output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      tmo(++n);
    end while (pcl !== 1'b1);
    v = pcv;
  endtask
  // every entry waits the full seven cycles before landing at the entry
  task automatic jmp;
    logic [14:0] v;
    int n;
    wait_pc(v, n);
    chk("jump", {17'h0, via_pkg::PC_ACK}, {17'h0, v} + 32'(n - 6));
  endtask
  function automatic logic [7:0] pick(input logic t, input logic [13:0] a);
    if (t) return 8'hfe;
    for (int i = 13; i >= 0; i--) if (a[i]) return 8'he2 + 8'(2 * i);
    return 8'he0;
  endfunction
  task automatic do_vis(input logic [14:0] pc, input logic [13:0] en, pd,
                        input logic t);
    logic [14:0] ta, v;
    logic [7:0]  hi, lo;
    int n;
    axw(via_pkg::REG_ENABLE, 32'(en));
    @(posedge clk_in);
    pend <= pd;
    vector_select_instr <= 1'b1;
    vpc <= pc;
    @(posedge clk_in);
    vector_select_instr <= 1'b0;
    pend <= 14'($urandom);
    ta = {pc[14:8] + 7'(pc[7:0] == 8'hff), pick(t, en & pd)};
    hi = {1'b1, ta[13:7]};
    lo = ta[7:0] ^ 8'h5b;
    wait_pc(v, n);
    chk("table", 32'(ta), 32'(v));
    wait_pc(v, n);
    chk("vector", 32'({hi[6:0], lo, 8'(3)}), 32'({v, 8'(n)}));
  endtask
  task automatic fetch(input logic [14:0] a, input logic [7:0] r, ed,
                       input logic ep);
    @(posedge clk_in);
    fv <= 1'b1;
    fa <= a;
    fr <= r;
    @(posedge clk_in);
    fv <= 1'b0;
    fr <= ~r;
    @(negedge clk_in);
    chk("fetch", 32'({1'b1, ed, ep, ep ? a : 15'h0}),
        32'({irl, fdata, push, push ? pusha : 15'h0}));
    if (ep) jmp();
  endtask
  task automatic ack(input logic ep);
    @(posedge clk_in);
    ist <= 1'b1;
    npc <= 15'($urandom);
    @(posedge clk_in);
    ist <= 1'b0;
    @(negedge clk_in);
    chk("ack", 32'({ep, ep ? npc : 15'h0}), 32'({push, push ? pusha : 15'h0}));
    if (ep) jmp();
  endtask
  initial begin
    logic [13:0] e, p;
    void'($urandom(59));
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk("idle", 32'h0, 32'({pcl, push, busy, global_irq_enable, fdata}));
    rdchk(via_pkg::REG_CTRL, 32'h0, via_pkg::RESP_OKAY);
    rdchk(via_pkg::REG_ENABLE, 32'h0, via_pkg::RESP_OKAY);
    rdchk(8'h10, 32'h0, via_pkg::RESP_DECERR);
    for (int i = 0; i < 24; i++) begin
      e = (i == 0) ? 14'h0 : (i == 1) ? 14'h3fff : 14'($urandom);
      p = (i == 1) ? 14'h1000 : 14'($urandom);
      do_vis((i == 2) ? 15'h00ff : 15'($urandom), e, p, 1'b0);
    end
    rdchk(via_pkg::REG_ACTIVE, 32'(e & pend), via_pkg::RESP_OKAY);
    axw(via_pkg::REG_CTRL, 32'h1);
    axw(via_pkg::REG_ENABLE, 32'h3fff);
    fetch(15'h0010, 8'h3c, 8'h3c, 1'b0);
    fetch(15'h0100, 8'h12, 8'h00, 1'b1);
    @(posedge clk_in);
    pend <= 14'h0801;
    rdchk(via_pkg::REG_CTRL, 32'h1, via_pkg::RESP_OKAY);
    rdchk(via_pkg::REG_ACTIVE, 32'h0801, via_pkg::RESP_OKAY);
    ack(1'b0);
    do_vis(15'h0123, 14'h3fff, 14'h0801, 1'b1);
    rdchk(via_pkg::REG_VECTOR, 32'h03a500fe, via_pkg::RESP_OKAY);
    fetch(15'h7fff, 8'h55, 8'h00, 1'b1);
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    pend <= 14'h0801;
    ack(1'b1);
    rdchk(via_pkg::REG_CTRL, 32'h0, via_pkg::RESP_OKAY);
    @(posedge clk_in);
    ret <= 1'b1;
    @(posedge clk_in);
    ret <= 1'b0;
    rdchk(via_pkg::REG_CTRL, 32'h1, via_pkg::RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      pop <= 1'b1;
      sp <= (i == 1) ? 8'h70 : 8'h6f;
      @(posedge clk_in);
      pop <= 1'b0;
      @(negedge clk_in);
      chk("pop", 32'({1'(i), (i == 1) ? 15'h7fff : 15'h0}),
          32'({pcl, pcl ? pcv : 15'h0}));
    end
    test_done();
  end
endmodule
`default_nettype wire
